// file: cassette_sequencer.sv
/*
 cassette motor and carrier sequencer: record and read latches, motor
 outputs, carrier delay one-shot, record-off decoding, fsk record path,
 carrier-gated 16x clock, and an avalon-mm register slave.
 assumes host data, clock_16x_in and tape_in come from outside the clock
 domain; the host serialiser keeps its own character framing.
*/
`timescale 1ns/1ps
module cassette_sequencer
	import cassette_pkg::*;
#(
	parameter logic [CNT_W-1:0] CARRIER_DELAY = CNT_W'(CARRIER_DELAY_CYC)
)(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic host_txd,
	input wire logic clock_16x_in,
	input wire logic tape_in,
	output logic clock_16x_out,
	output logic rx_data_out,
	output logic mic_audio,
	output logic rec_motor,
	output logic read_motor,
	output logic carrier_led
);
	typedef enum logic [1:0] {REC_IDLE, REC_DELAY, REC_CARRIER} rec_state_e;
	typedef enum logic [1:0] {SH_IDLE, SH_START, SH_DATA, SH_STOP} shift_state_e;

	rec_state_e rec_q;
	rec_state_e rec_d;
	shift_state_e sh_q;
	shift_state_e sh_d;
	logic [2:0] ctrl_q;
	logic [CNT_W-1:0] delay_q;
	logic [CNT_W-1:0] timer_q;
	logic [CNT_W-1:0] timer_d;
	logic [1:0] txd_sync_q;
	logic [1:0] clk_sync_q;
	logic [1:0] tape_sync_q;
	logic [BIT_W-1:0] bit_cnt_q;
	logic [2:0] bit_idx_q;
	logic [7:0] char_q;
	logic [7:0] last_char_q;
	logic eor_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic mic_q;
	logic rxd_q;
	logic clk16_q;
	wire logic txd;
	wire logic tape;
	wire logic auto_mode;
	wire logic rec_on;
	wire logic read_on;
	wire logic det;
	wire logic half_bit;
	wire logic full_bit;
	wire logic char_done;
	wire logic rec_off_hit;
	wire logic ctrl_hit;
	wire logic delay_hit;
	wire logic access;
	wire logic ctrl_sel;
	wire logic status_sel;
	wire logic delay_sel;
	wire logic rxchar_sel;
	wire logic [STATUS_W-1:0] status;
	wire logic [31:0] rd_mux;
	tone_if tone ();

	// two-flop synchronisers for the outside inputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			txd_sync_q <= 2'h3;
			clk_sync_q <= 2'h0;
			tape_sync_q <= 2'h0;
		end else begin
			txd_sync_q <= {txd_sync_q[0], host_txd};
			clk_sync_q <= {clk_sync_q[0], clock_16x_in};
			tape_sync_q <= {tape_sync_q[0], tape_in};
		end
	end
	assign txd = txd_sync_q[1];
	assign tape = tape_sync_q[1];

	// mode and latch decoding
	assign auto_mode = ctrl_q[CTRL_AUTO];
	assign rec_on = ctrl_q[CTRL_REC];
	assign read_on = ctrl_q[CTRL_READ];

	// motors: manual mode runs both always, auto follows the latches
	assign rec_motor = auto_mode ? rec_on : 1'b1;
	assign read_motor = auto_mode ? read_on : 1'b1;

	// record sequence: one-shot delay in auto mode, immediate in manual
	always_comb begin
		rec_d = rec_q;
		timer_d = timer_q;
		case (rec_q)
			REC_IDLE: begin
				timer_d = '0;
				if (rec_on) begin
					rec_d = auto_mode ? REC_DELAY : REC_CARRIER;
				end
			end
			REC_DELAY: begin
				timer_d = timer_q + CNT_W'(1);
				if (!rec_on) begin
					rec_d = REC_IDLE;
				end else if (timer_q >= delay_q) begin
					rec_d = REC_CARRIER;
				end
			end
			REC_CARRIER: begin
				if (!rec_on) begin
					rec_d = REC_IDLE;
				end
			end
			default: rec_d = REC_IDLE;
		endcase
	end
	assign carrier_led = (rec_q == REC_CARRIER);

	// tone runs when carrying, and always in manual mode, as a mark carrier while not carrying
	assign tone.enable = carrier_led || !auto_mode;
	assign tone.bit_val = carrier_led ? mic_q : 1'b1;
	assign mic_audio = tone.audio;

	fsk_modulator u_mod (
		.clock(clock),
		.rst_b(rst_b),
		.tone(tone)
	);

	// character tracker on the host line, bit timed at 300 baud
	assign half_bit = (bit_cnt_q == BIT_W'(BIT_CYCLES / 2));
	assign full_bit = (bit_cnt_q == BIT_W'(BIT_CYCLES - 1));
	assign char_done = (sh_q == SH_STOP) && full_bit;
	assign rec_off_hit = char_done && (char_q == RECORD_OFF_CODE);
	always_comb begin
		sh_d = sh_q;
		case (sh_q)
			SH_IDLE: if (!txd) sh_d = SH_START;
			SH_START: if (full_bit) sh_d = SH_DATA;
			SH_DATA: if (full_bit && bit_idx_q == 3'h7) sh_d = SH_STOP;
			SH_STOP: if (full_bit) sh_d = SH_IDLE;
			default: sh_d = SH_IDLE;
		endcase
	end

	// shift state, bit counter, bit index and data shifter
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sh_q <= SH_IDLE;
			bit_cnt_q <= '0;
			bit_idx_q <= '0;
			char_q <= '0;
		end else begin
			sh_q <= sh_d;
			bit_cnt_q <= (sh_q == SH_IDLE || full_bit) ? '0 : bit_cnt_q + BIT_W'(1);
			if (sh_q == SH_DATA && half_bit) begin
				char_q <= {txd, char_q[7:1]};
			end
			if (sh_q == SH_DATA && full_bit) begin
				bit_idx_q <= bit_idx_q + 3'h1;
			end
		end
	end

	// record data follows the host line, record-off char included
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mic_q <= 1'b1;
		end else begin
			mic_q <= txd;
		end
	end

	// readback gating: data passes only under carrier, 16x clock also while the read latch is off
	carrier_detector u_det (
		.clock(clock),
		.rst_b(rst_b),
		.enable(read_on),
		.tape_in(tape),
		.detected(det)
	);

	// gated 16x clock: stopped while the read latch waits for carrier
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clk16_q <= 1'b0;
		end else begin
			clk16_q <= clk_sync_q[1] && (det || !read_on);
		end
	end

	// tape data: held marking until carrier is detected
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxd_q <= 1'b1;
		end else begin
			rxd_q <= (read_on && det) ? tape : 1'b1;
		end
	end
	assign clock_16x_out = clk16_q;
	assign rx_data_out = rxd_q;

	// register select decode, shared by read mux and write strobes
	function automatic logic reg_sel(input logic [3:0] addr, input logic [3:0] offset);
		return addr == offset;
	endfunction : reg_sel

	// avalon slave: one wait state, answer on the second edge
	assign access = (read || write) && !ack_q;
	assign waitrequest = access;
	assign ctrl_sel = reg_sel(address, REG_CTRL);
	assign status_sel = reg_sel(address, REG_STATUS);
	assign delay_sel = reg_sel(address, REG_DELAY);
	assign rxchar_sel = reg_sel(address, REG_RXCHAR);
	assign ctrl_hit = write && ack_q && ctrl_sel;
	assign delay_hit = write && ack_q && delay_sel;
	assign status = {eor_q, read_motor, rec_motor, det, carrier_led, read_on, rec_on};
	assign rd_mux = ctrl_sel ? {29'h0, ctrl_q} :
		status_sel ? {25'h0, status} :
		delay_sel ? delay_q :
		rxchar_sel ? {24'h0, last_char_q} : 32'h0;
	assign readdata = rdata_q;

	// bus handshake and read data capture
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= access;
			if (access && read) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// record sequencer state and one-shot timer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rec_q <= REC_IDLE;
			timer_q <= '0;
		end else begin
			rec_q <= rec_d;
			timer_q <= timer_d;
		end
	end

	// carrier delay register, software adjustable
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			delay_q <= CARRIER_DELAY;
		end else if (delay_hit) begin
			delay_q <= writedata;
		end
	end

	// last character seen on the host line
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			last_char_q <= 8'h0;
		end else if (char_done) begin
			last_char_q <= char_q;
		end
	end

	// control latches; a decoded record-off clears the record latch in auto mode
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RESET;
		end else if (rec_off_hit && auto_mode) begin
			ctrl_q[CTRL_REC] <= 1'b0;
		end else if (ctrl_hit) begin
			ctrl_q <= writedata[2:0];
		end
	end

	// end-of-record flag: set wins over a clearing control write
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			eor_q <= 1'b0;
		end else if (rec_off_hit) begin
			eor_q <= 1'b1;
		end else if (ctrl_hit) begin
			eor_q <= 1'b0;
		end
	end
endmodule : cassette_sequencer

// file: cassette_pkg.sv
/*
 package for the cassette motor and carrier sequencer: register offsets,
 field positions, reset values and timing constants.
 assumes a 250 MHz system clock.
*/
package cassette_pkg;
	localparam int CLOCK_HZ = 250_000_000;
	localparam int BAUD = 300;
	localparam int MARK_HZ = 2400;
	localparam int SPACE_HZ = 1200;
	// half periods of the two fsk tones, in clock cycles
	localparam int MARK_HALF = CLOCK_HZ / (2 * MARK_HZ);
	localparam int SPACE_HALF = CLOCK_HZ / (2 * SPACE_HZ);
	// one bit time on tape
	localparam int BIT_CYCLES = CLOCK_HZ / BAUD;
	localparam int TONE_W = 20;
	localparam int BIT_W = 20;
	// default carrier delay one-shot, in milliseconds
	localparam int CARRIER_DELAY_MS = 1000;
	localparam int CARRIER_DELAY_CYC = (CARRIER_DELAY_MS / 1000) * CLOCK_HZ;
	// carrier-detect lag after tones vanish, in microseconds
	localparam int LOSS_LAG_US = 2000;
	localparam int LOSS_LAG_CYC = (LOSS_LAG_US * (CLOCK_HZ / 1_000_000));
	// carrier-detect qualify time before data is passed, in microseconds
	localparam int QUAL_US = 10000;
	localparam int QUAL_CYC = (QUAL_US * (CLOCK_HZ / 1_000_000));
	localparam int CNT_W = 32;
	localparam logic [7:0] RECORD_OFF_CODE = 8'h14;
	// register byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_DELAY = 4'h8;
	localparam logic [3:0] REG_RXCHAR = 4'hC;
	// control fields
	localparam int CTRL_REC = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_AUTO = 2;
	// status fields
	localparam int ST_REC = 0;
	localparam int ST_READ = 1;
	localparam int ST_CARRIER_EN = 2;
	localparam int ST_CARRIER_DET = 3;
	localparam int ST_REC_MOTOR = 4;
	localparam int ST_READ_MOTOR = 5;
	localparam int ST_EOR_SEEN = 6;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int STATUS_W = 7;
endpackage : cassette_pkg

// file: tone_if.sv
/*
 interface carrying tone generator controls and audio output between
 the sequencer and its fsk modulator.
 assumes a single clock domain.
*/
`timescale 1ns/1ps
interface tone_if;
	logic enable;
	logic bit_val;
	logic audio;
	modport ctrl (output enable, output bit_val, input audio);
	modport gen (input enable, input bit_val, output audio);
endinterface : tone_if

// file: fsk_modulator.sv
/*
 fsk modulator: square wave at the mark tone for a one and at the space
 tone for a zero, silent while disabled.
 assumes the sequencer steps bit_val only at bit boundaries.
*/
`timescale 1ns/1ps
module fsk_modulator
	import cassette_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	tone_if.gen tone
);
	logic [TONE_W-1:0] cnt_q;
	logic [TONE_W-1:0] cnt_d;
	logic audio_q;
	logic audio_d;
	wire logic [TONE_W-1:0] half_lim;
	wire logic wrap;

	// half period chosen by the bit: mark high tone, space low tone
	assign half_lim = tone.bit_val ? TONE_W'(MARK_HALF - 1) : TONE_W'(SPACE_HALF - 1);
	assign wrap = (cnt_q >= half_lim);
	assign cnt_d = (!tone.enable || wrap) ? '0 : cnt_q + TONE_W'(1);
	assign audio_d = !tone.enable ? 1'b0 : (wrap ? !audio_q : audio_q);
	assign tone.audio = audio_q;

	// tone phase registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			audio_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			audio_q <= audio_d;
		end
	end
endmodule : fsk_modulator

// file: carrier_detector.sv
/*
 carrier detector: watches the synchronised tape tone for edges; the
 carrier is declared after a qualify time of steady tone and dropped a
 lag after edges stop.
 assumes tape_in already passed two flip-flops.
*/
`timescale 1ns/1ps
module carrier_detector
	import cassette_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic tape_in,
	output logic detected
);
	logic prev_q;
	logic [CNT_W-1:0] quiet_q;
	logic [CNT_W-1:0] qual_q;
	logic det_q;
	wire logic edge_seen;
	wire logic lost;

	assign edge_seen = (tape_in != prev_q);
	assign lost = (quiet_q >= CNT_W'(LOSS_LAG_CYC));
	assign detected = det_q;

	// quiet timer restarts on every edge; qualify timer runs while enabled and tone is present
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= 1'b0;
			quiet_q <= '0;
			qual_q <= '0;
			det_q <= 1'b0;
		end else begin
			prev_q <= tape_in;
			quiet_q <= edge_seen ? '0 : (lost ? quiet_q : quiet_q + CNT_W'(1));
			if (!enable || lost) begin
				qual_q <= '0;
				det_q <= 1'b0;
			end else if (qual_q >= CNT_W'(QUAL_CYC)) begin
				det_q <= 1'b1;
			end else begin
				qual_q <= qual_q + CNT_W'(1);
			end
		end
	end
endmodule : carrier_detector

// file: cassette_checker.sv
/* port checker for the cassette sequencer.
 assumes it is bound to cassette_sequencer and sees its ports only. */
`timescale 1ns/1ps
module cassette_checker
	import cassette_pkg::*;
#(
	parameter logic [CNT_W-1:0] CARRIER_DELAY = CNT_W'(CARRIER_DELAY_CYC)
)(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic clock_16x_in,
	input wire logic clock_16x_out,
	input wire logic rx_data_out,
	input wire logic mic_audio,
	input wire logic rec_motor,
	input wire logic read_motor,
	input wire logic carrier_led
);
	logic [31:0] up_q, mot_q, hi_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ages since reset, since motor start and since last tone edge under carrier
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			up_q <= '0;
			mot_q <= '0;
			hi_q <= '0;
		end else begin
			up_q <= up_q + 32'(up_q < QUAL_CYC);
			mot_q <= rec_motor ? mot_q + 32'(mot_q < CARRIER_DELAY) : '0;
			hi_q <= ($changed(mic_audio) || !carrier_led) ? '0 : hi_q + 32'h1;
		end
	end
	sequence s_start;
		(read || write) && !$past(read || write);
	endsequence
	sequence s_one_wait;
		waitrequest ##1 !waitrequest;
	endsequence
	AST_WAIT_ONE: assert property (s_start |-> s_one_wait)
		else $error("wait state count wrong");
	AST_RX_IDLE: assert property (up_q < QUAL_CYC |-> rx_data_out)
		else $error("tape data passed before carrier");
	AST_GATE_SRC: assert property ($rose(clock_16x_out) |-> $past(clock_16x_in, 2)
		|| $past(clock_16x_in, 3) || $past(clock_16x_in, 4)) else $error("clock out rose alone");
	AST_LED_MOTOR: assert property ($rose(carrier_led) |-> rec_motor)
		else $error("carrier lit without motor");
	AST_LED_DELAY: assert property ($rose(carrier_led) && !read_motor
		|-> mot_q >= CARRIER_DELAY - 1) else $error("carrier lit early");
	AST_LED_OFF: assert property (!rec_motor && $past(!rec_motor) |-> !carrier_led)
		else $error("carrier lit with motor off");
	AST_MIC_QUIET: assert property (!read_motor && !carrier_led && $past(!carrier_led)
		|-> !mic_audio) else $error("tone before carrier");
	AST_MIC_HALF: assert property ($changed(mic_audio) && carrier_led
		|-> hi_q >= MARK_HALF - 2 && hi_q <= SPACE_HALF + 2) else $error("tone period wrong");
endmodule : cassette_checker
bind cassette_sequencer cassette_checker #(.CARRIER_DELAY(CARRIER_DELAY)) cassette_checker_i (
	.clock, .rst_b, .read, .write, .waitrequest, .clock_16x_in, .clock_16x_out,
	.rx_data_out, .mic_audio, .rec_motor, .read_motor, .carrier_led);

// file: tape_model.sv
/* playback recorder: squared tone on tape_in while its motor runs.
 assumes the tape level stands still while the motor is off. */
`timescale 1ns/1ps
module tape_model #(
	parameter int HALF = 100
)(
	input wire logic clock,
	input wire logic motor,
	output logic tape_in
);
	int cnt = 0;
	initial tape_in = 1'b0;
	// leading unmodulated carrier from motor start
	always @(posedge clock) begin
		if (!motor) begin
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			tape_in <= !tape_in;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : tape_model

// file: test_cassette_motor_carrier_sequencer.sv
/* testbench: registers, motor modes, record one-shot, tone, readback gating.
 assumes the checker binds itself and tape_model plays back. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: value %h", $time, a); end end
module test_cassette_motor_carrier_sequencer;
	import cassette_pkg::*;
	localparam logic [CNT_W-1:0] DEL = 32'h64;
	logic clock = 0, rst_b = 0, read = 0, write = 0, host_txd = 1, clock_16x_in = 0;
	logic clock_16x_out, rx_data_out, mic_audio, rec_motor, read_motor, carrier_led, tape_in;
	logic waitrequest, s;
	logic [3:0] address = '0;
	logic [31:0] writedata = '0, readdata, rd;
	logic [31:0] expq[$];
	int n_mismatch = 0, checked = 0, cycles = 0, seed = 65, n, m;
	cassette_sequencer #(.CARRIER_DELAY(DEL)) cassette_sequencer_i (.clock, .rst_b, .address,
		.read, .write, .writedata, .readdata, .waitrequest, .host_txd, .clock_16x_in, .tape_in,
		.clock_16x_out, .rx_data_out, .mic_audio, .rec_motor, .read_motor, .carrier_led);
	tape_model #(.HALF(100)) tape_model_i (.clock, .motor(read_motor), .tape_in);
	// clock and random terminal clock
	always #2 clock = !clock;
	always @(posedge clock) clock_16x_in <= 1'($random(seed));
	task automatic finish_test();
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// one bus access; a read notes its expected word
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		if (!wr)
			expq.push_back(d);
		do @(posedge clock); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	// counts edges until led (w=0) or mic (w=1) reaches lvl
	task automatic wait_for(input int w, input logic lvl);
		n = 0;
		s = w ? mic_audio : carrier_led;
		while (s !== lvl && n < 60000) begin
			@(posedge clock);
			n++;
			s = w ? mic_audio : carrier_led;
		end
	endtask : wait_for
	// read answers against the oldest note, and the hang limit
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (read && waitrequest === 1'b0) begin
			rd = expq.pop_front();
			`CHK(readdata, rd)
		end
		if (cycles == 70000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		`CHK({rec_motor, read_motor, carrier_led, rx_data_out}, 4'hD)
		rst_b <= 1'b1;
		bus(0, REG_CTRL, 32'h0);
		bus(0, REG_DELAY, DEL);
		n = $random(seed);
		bus(1, REG_DELAY, n);
		bus(0, REG_DELAY, n);
		bus(1, REG_DELAY, DEL);
		bus(1, 4'h2, n);
		bus(0, 4'h2, 32'h0);
		for (int v = 0; v < 8; v++) begin
			bus(1, REG_CTRL, v);
			bus(0, REG_CTRL, v);
			`CHK({rec_motor, read_motor}, v[2] ? {v[0], v[1]} : 2'h3)
		end
		// auto mode with latches off, so the one-shot starts from idle
		bus(1, REG_CTRL, 32'h4);
		host_txd <= 1'b1;
		bus(1, REG_CTRL, 32'h5);
		wait_for(0, 1'b1);
		`CHK(n >= DEL && n <= DEL + 3, 1'b1)
		// first mark half period, counted from carrier start
		wait_for(1, 1'b1);
		`CHK(n >= MARK_HALF - 2 && n <= MARK_HALF + 2, 1'b1)
		bus(0, REG_STATUS, 32'h15);
		bus(1, REG_CTRL, 32'h4);
		repeat (2) @(posedge clock);
		`CHK({carrier_led, rec_motor}, 2'h0)
		bus(1, REG_CTRL, 32'h6);
		host_txd <= 1'b1;
		repeat (8) @(posedge clock);
		n = 0;
		m = 0;
		repeat (2000) begin
			@(posedge clock);
			n += int'(rx_data_out !== 1'b1);
			m += int'(clock_16x_out !== 1'b0);
		end
		`CHK(n, 0)
		`CHK(m, 0)
		host_txd <= 1'b1;
		bus(1, REG_CTRL, 32'h0);
		m = 0;
		repeat (64) begin
			@(posedge clock);
			m += int'(clock_16x_out === 1'b1);
		end
		`CHK(m > 0, 1'b1)
		finish_test();
	end
endmodule : test_cassette_motor_carrier_sequencer
